// File: hw/watchdog_timeout_response.sv
// Purpose: watchdog control register, timeout response and status.
// Assumes: i_reset is the external hardware reset.
// Notes:   a watchdog reset is signalled on o_system_reset and, through its event bit when unmasked, on o_irq.
`timescale 1ns/1ps
module watchdog_timeout_response
    import wdt_pkg::*;
#(
    parameter int unsigned P_CLOCK_HZ   = CLOCK_HZ,
    parameter int unsigned P_XTAL_HZ    = XTAL_HZ,
    parameter int unsigned P_BASE_TICKS = BASE_TICKS
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    input  wire logic [ADDR_WIDTH-1:0] i_address,
    input  wire logic [DATA_WIDTH-1:0] i_write_data,
    input  wire logic                  i_write,
    input  wire logic                  i_read,
    output logic [DATA_WIDTH-1:0]      o_read_data,
    output logic                       o_system_reset,
    output logic                       o_wdt_interrupt,
    output logic                       o_wdt_interrupt_high_priority,
    output logic                       o_irq
);

    ctrl_s                  ctrl_q;
    ctrl_s                  ctrl_d;
    unlock_state_e          unlock_q;
    unlock_state_e          unlock_d;
    logic [EVENT_WIDTH-1:0] event_q;
    logic [EVENT_WIDTH-1:0] event_d;
    logic [EVENT_WIDTH-1:0] mask_q;
    logic [DATA_WIDTH-1:0]  read_q;
    logic                   reset_q;
    logic                   nmi_q;

    logic                   ctrl_write;
    logic                   accept;
    logic                   refresh;
    logic                   tick;
    logic                   expire;
    logic [COUNT_WIDTH-1:0] count;
    logic                   immediate;
    logic                   reset_fire;
    logic                   irq_fire;
    logic                   status_clear;
    logic [DATA_WIDTH-1:0]  ctrl_view;

    ctrl_s                  ctrl_reset_value;
    assign ctrl_reset_value = ctrl_s'(CTRL_RESET[DATA_WIDTH-1:1]);

    // crystal time base and period counter
    xtal_tick_gen #(
        .P_CLOCK_HZ (P_CLOCK_HZ),
        .P_XTAL_HZ  (P_XTAL_HZ)
    ) u_tick (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .o_tick  (tick)
    );

    timeout_counter #(
        .P_BASE_TICKS (P_BASE_TICKS)
    ) u_counter (
        .i_clock  (i_clock),
        .i_reset  (i_reset),
        .i_tick   (tick),
        .i_run    (ctrl_q.watchdog_enable_refresh && !immediate),
        .i_clear  (refresh),
        .i_code   (ctrl_q.timeout_prescale_code[2:0]),
        .o_expire (expire),
        .o_count  (count)
    );

    // access decode
    assign ctrl_write   = i_write && (i_address == CTRL_ADDR);
    assign accept       = ctrl_write && (unlock_q == UNLOCK_ARMED); // [R13]
    assign refresh      = accept && i_write_data[ENABLE_BIT]; // [R12]
    assign status_clear = accept && !i_write_data[STATUS_BIT]; // [R9]

    // codes of 8 and above act as zero timeout
    assign immediate  = ctrl_q.timeout_prescale_code >= IMMEDIATE_CODE;

    // response select
    assign reset_fire = ctrl_q.watchdog_enable_refresh &&
                        (immediate || // [R2]
                         (expire && !ctrl_q.interrupt_response_select)); // [R4]
    assign irq_fire   = ctrl_q.watchdog_enable_refresh && !immediate &&
                        expire && ctrl_q.interrupt_response_select; // [R4]

    // unlock sequence: arming write, then the very next access
    always_comb begin
        unlock_d = unlock_q;
        unique case (unlock_q)
            UNLOCK_IDLE: begin
                if (ctrl_write && i_write_data[UNLOCK_BIT]) begin
                    unlock_d = UNLOCK_ARMED; // [R13]
                end
            end
            UNLOCK_ARMED: begin
                if (i_write || i_read) begin
                    unlock_d = UNLOCK_IDLE; // [R13]
                end
            end
            default: begin
                unlock_d = UNLOCK_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            unlock_q <= UNLOCK_IDLE;
        end else begin
            unlock_q <= unlock_d;
        end
    end

    // control register next value
    always_comb begin
        ctrl_d = ctrl_q;
        if (accept) begin
            ctrl_d.timeout_prescale_code =
                i_write_data[PRESCALE_MSB:PRESCALE_LSB];
            ctrl_d.interrupt_response_select = i_write_data[IRQ_SEL_BIT];
            ctrl_d.watchdog_enable_refresh   = i_write_data[ENABLE_BIT];
        end
        if (status_clear) begin
            ctrl_d.timeout_status_flag = 1'b0; // [R9]
        end
        if (reset_fire) begin
            ctrl_d.timeout_prescale_code =
                ctrl_reset_value.timeout_prescale_code;
            ctrl_d.interrupt_response_select = 1'b0;
            ctrl_d.watchdog_enable_refresh   = 1'b0;
        end
        if (reset_fire || irq_fire) begin
            ctrl_d.timeout_status_flag = 1'b1; // [R8] [R10]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_q <= ctrl_reset_value; // [R9]
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // response outputs
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            reset_q <= 1'b0;
            nmi_q   <= 1'b0;
        end else begin
            reset_q <= reset_fire; // [R1] [R2]
            nmi_q   <= irq_fire; // [R5] [R7]
        end
    end

    assign o_system_reset                = reset_q;
    assign o_wdt_interrupt               = nmi_q; // [R5]
    assign o_wdt_interrupt_high_priority = 1'b1; // [R6]

    // sticky events, write one to clear, set wins
    always_comb begin
        event_d = event_q;
        if (i_write && (i_address == EVENT_ADDR)) begin
            event_d = event_q & ~i_write_data[EVENT_WIDTH-1:0];
        end
        if (irq_fire) begin
            event_d[EV_INTERVAL_BIT] = 1'b1;
        end
        if (reset_fire) begin
            event_d[EV_RESET_BIT] = 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            event_q <= EVENT_RESET;
        end else begin
            event_q <= event_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mask_q <= EVENT_RESET;
        end else if (i_write && (i_address == MASK_ADDR)) begin
            mask_q <= i_write_data[EVENT_WIDTH-1:0];
        end
    end

    assign o_irq = |(event_q & mask_q);

    // read port, data valid one cycle after the strobe only
    assign ctrl_view = {ctrl_q.timeout_prescale_code,
                        ctrl_q.interrupt_response_select,
                        ctrl_q.timeout_status_flag,
                        ctrl_q.watchdog_enable_refresh,
                        unlock_q == UNLOCK_ARMED};

    always_ff @(posedge i_clock) begin
        if (i_reset || !i_read) begin
            read_q <= '0;
        end else begin
            unique case (i_address)
                CTRL_ADDR:  read_q <= ctrl_view;
                EVENT_ADDR: read_q <= {{(DATA_WIDTH-EVENT_WIDTH){1'b0}},
                                       event_q};
                MASK_ADDR:  read_q <= {{(DATA_WIDTH-EVENT_WIDTH){1'b0}},
                                       mask_q};
                default:    read_q <= '0;
            endcase
        end
    end

    assign o_read_data = read_q;

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    logic [COUNT_WIDTH-1:0] base_c;
    assign base_c = COUNT_WIDTH'(P_BASE_TICKS);

    sequence s_arm;
        ctrl_write && i_write_data[UNLOCK_BIT] && unlock_q == UNLOCK_IDLE;
    endsequence

    sequence s_unlocked_write;
        ctrl_write && !reset_fire;
    endsequence

    sequence s_interval_expiry;
        irq_fire;
    endsequence

    chk_period_length: assert property ( // [R11] [R1]
        expire |-> count ==
            period_last(ctrl_q.timeout_prescale_code[2:0], base_c))
        else $error("expiry not at end of selected period");

    chk_immediate_reset: assert property ( // [R2]
        (ctrl_q.watchdog_enable_refresh && immediate)
        |=> o_system_reset && !o_wdt_interrupt)
        else $error("immediate code did not reset at once");

    chk_irq_not_reset: assert property ( // [R4]
        s_interval_expiry |=> o_wdt_interrupt && !o_system_reset)
        else $error("interrupt mode expiry did not interrupt");

    chk_interval_rerun: assert property ( // [R7]
        (irq_fire && !accept) |=> ctrl_q.watchdog_enable_refresh &&
                                  count == '0)
        else $error("interval timer stopped after expiry");

    chk_status_set: assert property ( // [R8]
        (reset_fire || irq_fire) |=> ctrl_q.timeout_status_flag)
        else $error("timeout did not set status flag");

    chk_status_clear: assert property ( // [R9]
        $fell(ctrl_q.timeout_status_flag) |-> $past(status_clear))
        else $error("status flag cleared without a zero write");

    chk_reset_keeps_flag: assert property ( // [R10]
        o_system_reset |-> ctrl_q.timeout_status_flag &&
                           !ctrl_q.watchdog_enable_refresh)
        else $error("watchdog reset lost status flag");

    chk_refresh_clears: assert property ( // [R12]
        (refresh && !reset_fire) |=> count == '0 &&
                                     ctrl_q.watchdog_enable_refresh)
        else $error("refresh did not restart the counter");

    chk_locked_write: assert property ( // [R13]
        (ctrl_write && unlock_q == UNLOCK_IDLE && !reset_fire)
        |=> $stable(ctrl_q.timeout_prescale_code) &&
            $stable(ctrl_q.interrupt_response_select))
        else $error("locked write changed control register");

    chk_unlock_sequence: assert property ( // [R13]
        s_arm ##1 s_unlocked_write
        |=> ctrl_q.timeout_prescale_code ==
            $past(i_write_data[PRESCALE_MSB:PRESCALE_LSB]))
        else $error("unlocked write not taken");

    chk_fixed_priority: assert property ( // [R6] [R5]
        o_wdt_interrupt |-> o_wdt_interrupt_high_priority)
        else $error("watchdog interrupt lost high priority");

    chk_reset_response: assert property ( // [R1] [R4]
        (expire && !ctrl_q.interrupt_response_select)
        |=> o_system_reset && !o_wdt_interrupt)
        else $error("reset mode expiry did not reset");

    chk_status_holds: assert property ( // [R9]
        (accept && i_write_data[STATUS_BIT] && ctrl_q.timeout_status_flag)
        |=> ctrl_q.timeout_status_flag)
        else $error("writing one cleared the status flag");

    chk_arm_single: assert property ( // [R13]
        (unlock_q == UNLOCK_ARMED && (i_write || i_read))
        |=> unlock_q == UNLOCK_IDLE)
        else $error("unlock stayed armed past the next access");

endmodule

// File: hw/wdt_pkg.sv
// Purpose: shared constants, field layouts and types of the watchdog.
// Assumes: 50 MHz system clock, crystal time base of 32.768 kHz.
// Notes:   byte-wide register port, one register per address.
//
// Behaviour
// R1: prescale codes 4 to 7 expire after 250, 500, 1000 and 2000 ms, then reset or interrupt as selected.
// R2: prescale code 8 means zero timeout and an immediate system reset whatever the select bit says.
// R3: software keeps prescale codes at or below 8, higher codes being reserved.
// R4: with the interrupt select bit (bit 3) set expiry raises an interrupt, otherwise it resets the system.
// R5: the watchdog interrupt is never gated by the global interrupt enable.
// R6: the watchdog interrupt is fixed at high priority in hardware.
// R7: in interrupt mode the watchdog runs on as an interval timer, interrupting once per period.
// R8: every timeout sets the status flag (bit 2) in both response modes.
// R9: the status flag clears only on a software write of 0 or on the external reset.
// R10: a reset made by the watchdog itself leaves the status flag set.
// R11: the period is two to the prescale code times 512 crystal periods.
// R12: setting the enable bit enables the watchdog and clears its counter; software repeats it each period.
// R13: a control write is taken only as the access right after the one that sets the unlock bit.
package wdt_pkg;

    localparam int unsigned CLOCK_HZ         = 50_000_000;
    localparam int unsigned XTAL_HZ          = 32_768;
    localparam int unsigned BASE_TICKS       = 512;
    localparam int unsigned COUNT_WIDTH      = 17;
    localparam int unsigned ADDR_WIDTH       = 8;
    localparam int unsigned DATA_WIDTH       = 8;

    localparam logic [7:0]  CTRL_ADDR        = 8'h00;
    localparam logic [7:0]  EVENT_ADDR       = 8'h01;
    localparam logic [7:0]  MASK_ADDR        = 8'h02;

    localparam int unsigned PRESCALE_MSB     = 7;
    localparam int unsigned PRESCALE_LSB     = 4;
    localparam int unsigned IRQ_SEL_BIT      = 3;
    localparam int unsigned STATUS_BIT       = 2;
    localparam int unsigned ENABLE_BIT       = 1;
    localparam int unsigned UNLOCK_BIT       = 0;

    localparam logic [7:0]  CTRL_RESET       = 8'h10;
    localparam logic [3:0]  IMMEDIATE_CODE   = 4'h8;

    localparam int unsigned EVENT_WIDTH      = 2;
    localparam int unsigned EV_INTERVAL_BIT  = 0;
    localparam int unsigned EV_RESET_BIT     = 1;
    localparam logic [1:0]  EVENT_RESET      = 2'h0;

    typedef struct packed {
        logic [3:0] timeout_prescale_code;
        logic       interrupt_response_select;
        logic       timeout_status_flag;
        logic       watchdog_enable_refresh;
    } ctrl_s;

    typedef enum logic [1:0] {
        UNLOCK_IDLE  = 2'b01,
        UNLOCK_ARMED = 2'b10
    } unlock_state_e;

    // last count of a period: base ticks shifted by the code, minus one
    function automatic logic [COUNT_WIDTH-1:0] period_last(
        input logic [2:0]             code,
        input logic [COUNT_WIDTH-1:0] base
    );
        logic [COUNT_WIDTH-1:0] span;
        span = base << code;
        return span - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    endfunction

endpackage

// File: hw/xtal_tick_gen.sv
// Purpose: one-cycle crystal tick derived from the system clock.
// Assumes: XTAL_HZ not above CLOCK_HZ.
// Notes:   phase accumulator, exact average rate, jitter one clock.
`timescale 1ns/1ps
module xtal_tick_gen
    import wdt_pkg::*;
#(
    parameter int unsigned P_CLOCK_HZ = CLOCK_HZ,
    parameter int unsigned P_XTAL_HZ  = XTAL_HZ
) (
    input  wire logic i_clock,
    input  wire logic i_reset,
    output logic      o_tick
);

    initial begin
        if (P_XTAL_HZ == 0 || P_XTAL_HZ > P_CLOCK_HZ) begin
            $error("xtal rate must be nonzero and not above clock rate");
        end
    end

    localparam logic [31:0] STEP = 32'(P_XTAL_HZ);
    localparam logic [31:0] WRAP = 32'(P_CLOCK_HZ);

    logic [31:0] acc_q;
    logic [31:0] sum;
    logic        tick_q;

    assign sum = acc_q + STEP;

    // accumulate crystal phase, tick on each wrap
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            acc_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (sum >= WRAP) begin
            acc_q  <= sum - WRAP;
            tick_q <= 1'b1;
        end else begin
            acc_q  <= sum;
            tick_q <= 1'b0;
        end
    end

    assign o_tick = tick_q;

endmodule

// File: hw/timeout_counter.sv
// Purpose: counts crystal ticks up to the selected timeout period.
// Assumes: code 0 to 7; the caller handles the immediate code.
// Notes:   wraps to zero on expiry so it serves as an interval timer.
`timescale 1ns/1ps
module timeout_counter
    import wdt_pkg::*;
#(
    parameter int unsigned P_BASE_TICKS = BASE_TICKS
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_reset,
    input  wire logic                   i_tick,
    input  wire logic                   i_run,
    input  wire logic                   i_clear,
    input  wire logic [2:0]             i_code,
    output logic                        o_expire,
    output logic [COUNT_WIDTH-1:0]      o_count
);

    initial begin
        if (P_BASE_TICKS == 0 || P_BASE_TICKS > BASE_TICKS) begin
            $error("base ticks must be between 1 and 512");
        end
    end

    localparam logic [COUNT_WIDTH-1:0] BASE = COUNT_WIDTH'(P_BASE_TICKS);

    logic [COUNT_WIDTH-1:0] count_q;
    logic                   at_last;

    assign at_last  = count_q >= period_last(i_code, BASE);
    assign o_expire = i_run && !i_clear && i_tick && at_last; // [R11]

    always_ff @(posedge i_clock) begin
        if (i_reset || i_clear || !i_run) begin
            count_q <= '0; // [R12]
        end else if (o_expire) begin
            count_q <= '0; // [R7]
        end else if (i_tick) begin
            count_q <= count_q + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign o_count = count_q;

endmodule

// File: verification/tb_watchdog_timeout_response.sv
// Purpose: self-checking bench for the watchdog timeout response block.
// Assumes: tick every clock (crystal rate set to clock rate), base of 4.
// Notes:   the global interrupt enable is no input, so nothing can gate it.
`timescale 1ns/1ps
module tb_watchdog_timeout_response;
    import wdt_pkg::*;

    localparam int unsigned BT = 4;

    logic                  i_clock;
    logic                  i_reset;
    logic [ADDR_WIDTH-1:0] i_address;
    logic [DATA_WIDTH-1:0] i_write_data;
    logic                  i_write;
    logic                  i_read;
    logic [DATA_WIDTH-1:0] o_read_data;
    logic                  o_system_reset;
    logic                  o_wdt_interrupt;
    logic                  o_wdt_interrupt_high_priority;
    logic                  o_irq;
    int                    num_errors;
    int                    total_checks;
    int                    num_resets;
    int                    num_ints;

    watchdog_timeout_response #(
        .P_CLOCK_HZ   (50_000_000),
        .P_XTAL_HZ    (50_000_000),
        .P_BASE_TICKS (BT)
    ) u_dut (
        .i_clock                       (i_clock),
        .i_reset                       (i_reset),
        .i_address                     (i_address),
        .i_write_data                  (i_write_data),
        .i_write                       (i_write),
        .i_read                        (i_read),
        .o_read_data                   (o_read_data),
        .o_system_reset                (o_system_reset),
        .o_wdt_interrupt               (o_wdt_interrupt),
        .o_wdt_interrupt_high_priority (o_wdt_interrupt_high_priority),
        .o_irq                         (o_irq)
    );

    always #10 i_clock = ~i_clock;

    // pulse counters of both responses
    always @(posedge i_clock) begin
        if (o_system_reset === 1'b1) num_resets++;
        if (o_wdt_interrupt === 1'b1) num_ints++;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_write      <= 1'b1;
        i_address    <= a;
        i_write_data <= d;
        @(posedge i_clock);
        i_write      <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_read    <= 1'b1;
        i_address <= a;
        @(posedge i_clock);
        i_read    <= 1'b0;
        #1;
        check({8'h00, o_read_data}, {8'h00, exp});
    endtask

    // unlock, then the control write in the very next cycle
    task automatic wctrl(input logic [7:0] v);
        @(posedge i_clock);
        i_write      <= 1'b1;
        i_address    <= CTRL_ADDR;
        i_write_data <= 8'h01;
        @(posedge i_clock);
        i_write_data <= v;
        @(posedge i_clock);
        i_write      <= 1'b0;
    endtask

    // cycles until a pulse: 0 interrupt, 1 reset; limit+1 if none
    task automatic wait_pulse(input int which, input int limit,
                              output int n);
        n = limit + 1;
        for (int i = 1; i <= limit; i++) begin
            @(posedge i_clock);
            #1;
            if ((which == 0 && o_wdt_interrupt === 1'b1) ||
                (which == 1 && o_system_reset === 1'b1)) begin
                n = i;
                break;
            end
        end
    endtask

    task automatic do_reset();
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
    endtask

    task automatic s_reset_values();
        rd_check(CTRL_ADDR, CTRL_RESET);
        rd_check(EVENT_ADDR, 8'h00);
        rd_check(MASK_ADDR, 8'h00);
        rd_check(8'h3C, 8'h00);
        check({15'h0, o_wdt_interrupt_high_priority}, 16'h0001);
    endtask

    task automatic s_lock();
        wr(CTRL_ADDR, 8'h72);
        rd_check(CTRL_ADDR, CTRL_RESET);
        wr(CTRL_ADDR, 8'h01);
        rd_check(CTRL_ADDR, 8'h11);
        wr(CTRL_ADDR, 8'h72);
        rd_check(CTRL_ADDR, CTRL_RESET);
        wr(CTRL_ADDR, 8'h01);
        wr(CTRL_ADDR, 8'h30);
        rd_check(CTRL_ADDR, 8'h30);
    endtask

    task automatic s_interval();
        int n;
        int per;
        int r0;
        logic [3:0] c;
        for (int k = 4; k < 8; k++) begin
            c   = k[3:0];
            per = BT << k;
            r0  = num_resets;
            wctrl({c, 4'hA});
            wait_pulse(0, per + 8, n);
            check(16'(n >= per - 4 && n <= per + 4), 16'h0001);
            wait_pulse(0, per + 8, n);
            check(16'(n), 16'(per));
            rd_check(CTRL_ADDR, {c, 4'hE});
            check(16'(num_resets), 16'(r0));
        end
    endtask

    task automatic s_status();
        wctrl(8'h1C);
        rd_check(CTRL_ADDR, 8'h1C);
        wctrl(8'h18);
        rd_check(CTRL_ADDR, 8'h18);
        wctrl(8'h14);
        rd_check(CTRL_ADDR, 8'h10);
    endtask

    task automatic s_events();
        rd_check(EVENT_ADDR, 8'h01);
        #1;
        check({15'h0, o_irq}, 16'h0000);
        wr(MASK_ADDR, 8'h01);
        #1;
        check({15'h0, o_irq}, 16'h0001);
        wr(EVENT_ADDR, 8'h01);
        #1;
        check({15'h0, o_irq}, 16'h0000);
        rd_check(EVENT_ADDR, 8'h00);
    endtask

    task automatic s_refresh();
        int r0;
        r0 = num_resets;
        for (int k = 0; k < 6; k++) begin
            wctrl(8'h42);
            repeat (40) @(posedge i_clock);
        end
        check(16'(num_resets), 16'(r0));
        wctrl(8'h40);
    endtask

    task automatic s_reset_mode();
        int n;
        int i0;
        int r0;
        i0 = num_ints;
        r0 = num_resets;
        wr(MASK_ADDR, 8'h03);
        wctrl(8'h42);
        wait_pulse(1, 80, n);
        check(16'(n >= 60 && n <= 68), 16'h0001);
        check(16'(num_ints), 16'(i0));
        rd_check(CTRL_ADDR, 8'h14);
        rd_check(EVENT_ADDR, 8'h02);
        check(16'(num_resets), 16'(r0 + 1));
        #1;
        check({15'h0, o_irq}, 16'h0001);
        wr(EVENT_ADDR, 8'h02);
    endtask

    task automatic s_immediate();
        int n;
        int i0;
        i0 = num_ints;
        wctrl(8'h8A);
        wait_pulse(1, 4, n);
        check(16'(n <= 4), 16'h0001);
        check(16'(num_ints), 16'(i0));
        rd_check(CTRL_ADDR, 8'h14);
    endtask

    task automatic s_ext_reset();
        do_reset();
        rd_check(CTRL_ADDR, CTRL_RESET);
        rd_check(EVENT_ADDR, 8'h00);
        rd_check(MASK_ADDR, 8'h00);
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #400_000;
        num_errors++;
        summarize();
    end

    initial begin
        i_clock      = 1'b0;
        i_reset      = 1'b1;
        i_address    = 8'h00;
        i_write_data = 8'h00;
        i_write      = 1'b0;
        i_read       = 1'b0;
        num_errors   = 0;
        total_checks = 0;
        num_resets   = 0;
        num_ints     = 0;
        repeat (2) @(posedge i_clock);
        i_reset <= 1'b0;
        s_reset_values();
        s_lock();
        s_interval();
        s_status();
        s_events();
        s_refresh();
        s_reset_mode();
        s_immediate();
        s_ext_reset();
        summarize();
    end
endmodule
